// *** sim/bli_interval_tb.sv ***
// Self-checking bench for the segment update-interval stage
module bli_interval_tb
  import bli_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Design hookup
  // ****************************************
  logic clk, rst, ce;
  logic [BLI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  bli_ramp_t ramp;
  bli_upd_t upd;
  int err_count, checks;
  logic [15:0] rnd;
  logic [31:0] val, rd, fields, sts;
  logic [1:0] rsp;
  int i, k, n, gap;
  bli_interval DUT (.clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ramp(ramp), .upd(upd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic test_done();
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang(input string nm);
    $display("[FAIL] %s exp handshake got none", nm);
    err_count++;
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  function automatic logic [31:0] get_rnd();
    repeat (32) rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return {rnd, rnd[7:0], rnd[15:8]};
  endfunction
  function automatic logic [2:0] exp_idx(logic [7:0] d, logic f, logic asym);
    return asym ? {f, d[7:6]} : d[7:5];
  endfunction
  function automatic logic [3:0] exp_fld(logic [31:0] r, logic [2:0] s);
    return r[s*4 +: 4];
  endfunction
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w, ca, cw, got;
    aw = 0;
    w = 0;
    got = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int j = 0; j < 50 && !(aw && w); j++) begin
      @(negedge clk);
      ca = !aw && s_axi_awready;
      cw = !w && s_axi_wready;
      @(posedge clk);
      if (ca) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (cw) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (int j = 0; j < 50 && !got; j++) begin
      @(negedge clk);
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
    end
    s_axi_bready <= 1'b0;
    if (!(aw && w && got)) hang("write");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, got;
    ar = 0;
    got = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int j = 0; j < 50 && !got; j++) begin
      @(negedge clk);
      if (ar) got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (!ar && s_axi_arready) ar = 1;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!got) hang("read");
  endtask
  task automatic pe_pulse();
    @(posedge clk);
    ramp.period_end <= 1'b1;
    @(posedge clk);
    ramp.period_end <= 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_count = 0;
    checks = 0;
    rnd = 16'h000a;
    rst = 1'b1;
    ce = 1'b1;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_awvalid = 0;
    s_axi_wvalid = 0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 0;
    s_axi_arvalid = 0;
    s_axi_rready = 0;
    ramp = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    axi_rd(BLI_OFF_INTERVAL, rd, rsp);
    chk("interval reset", BLI_INTERVAL_RST, rd);
    axi_rd(BLI_OFF_CTRL, rd, rsp);
    chk("ctrl reset", BLI_CTRL_RST, rd);
    axi_rd(8'h40, rd, rsp);
    chk("unmapped rresp", BLI_RESP_SLVERR, rsp);
    chk("unmapped rdata", 32'h0000_0000, rd);
    axi_wr(8'h40, 32'hffff_ffff, rsp);
    chk("unmapped bresp", BLI_RESP_SLVERR, rsp);
    val = get_rnd();
    axi_wr(BLI_OFF_INTERVAL, val, rsp);
    axi_rd(BLI_OFF_INTERVAL, rd, rsp);
    chk("held not read", 32'h0000_0000, rd);
    pe_pulse();
    axi_rd(BLI_OFF_INTERVAL, rd, rsp);
    chk("no commit unapplied", 32'h0000_0000, rd);
    axi_wr(BLI_OFF_CTRL, 32'h0000_0002, rsp);
    pe_pulse();
    axi_rd(BLI_OFF_INTERVAL, rd, rsp);
    chk("commit applied", val, rd);
    for (k = 0; k < 2; k++) begin
      axi_wr(BLI_OFF_CTRL, 32'h0000_0002 | k, rsp);
      for (i = 0; i < 16; i++) begin
        rd = get_rnd();
        if (i == 0) rd = 32'h0000_01ff;
        if (i == 1) rd = 32'h0000_0000;
        @(posedge clk);
        ramp.duty_cycle <= rd[7:0];
        ramp.falling_phase_flag <= rd[8];
        repeat (2) @(posedge clk);
        #1;
        chk("segment index", exp_idx(rd[7:0], rd[8], k[0]), upd.segment_index);
        chk("selected field", exp_fld(val, exp_idx(rd[7:0], rd[8], k[0])), upd.wait_periods);
        // Status word mirrors the live index and the field it picks
        axi_rd(BLI_OFF_STATUS, sts, rsp);
        chk("status rresp", BLI_RESP_OKAY, rsp);
        chk("status index", exp_idx(rd[7:0], rd[8], k[0]), sts[BLI_STS_IDX_LSB +: BLI_IDX_W]);
        chk("status field", exp_fld(val, exp_idx(rd[7:0], rd[8], k[0])),
          sts[BLI_STS_SEL_LSB +: BLI_FIELD_W]);
      end
    end
    fields = 32'hf7a3_5c10;
    axi_wr(BLI_OFF_INTERVAL, fields, rsp);
    axi_wr(BLI_OFF_CTRL, 32'h0000_0002, rsp);
    pe_pulse();
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      ramp.duty_cycle <= k[2:0] << 5;
      ramp.period_end <= 1'b1;
      // Let at least one edge pass so the new index is in use before syncing
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (n < 40 && upd.duty_update !== 1'b1);
      if (upd.duty_update !== 1'b1) hang("first update");
      gap = 0;
      do begin
        @(posedge clk);
        #1;
        gap++;
      end while (gap < 40 && upd.duty_update !== 1'b1);
      chk("update gap", exp_fld(fields, k[2:0]) + 32'd1, gap);
      @(posedge clk);
      ramp.period_end <= 1'b0;
    end
    // byte strobes merge into the holding copy
    @(posedge clk);
    s_axi_wstrb <= 4'h1;
    axi_wr(BLI_OFF_INTERVAL, 32'hffff_ffff, rsp);
    chk("interval bresp", BLI_RESP_OKAY, rsp);
    s_axi_wstrb <= 4'hf;
    pe_pulse();
    axi_rd(BLI_OFF_INTERVAL, rd, rsp);
    chk("interval rresp", BLI_RESP_OKAY, rsp);
    chk("strobed commit", {fields[31:8], 8'hff}, rd);
    // Clock enable low freezes the stage and drops readies
    @(posedge clk);
    ramp.duty_cycle <= 8'he0;
    repeat (2) @(posedge clk);
    ce <= 1'b0;
    ramp.duty_cycle <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
    chk("frozen index", exp_idx(8'he0, 1'b0, 1'b0), upd.segment_index);
    chk("awready with ce low", 32'h0000_0000, s_axi_awready);
    chk("arready with ce low", 32'h0000_0000, s_axi_arready);
    @(posedge clk);
    ce <= 1'b1;
    test_done();
  end
endmodule

// *** src/bli_interval.sv ***
// Segment update-interval stage of the breathing LED PWM generator
//
// Behaviour
// - Eight 4-bit wait fields, one per segment
// - Field value n waits n plus one periods
// - Segment index k selects nibble k
// - Symmetric: index is duty bits seven to five
// - Asymmetric: falling flag, then duty bits seven, six
// - Shape select bit chooses index formation
// - Writes held; committed at period end when applying
// - Reads return committed value, not holding copy
//
// Local design decision: the AXI4-Lite interface to the registers.
module bli_interval
  import bli_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [BLI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [BLI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ramp side of the unit
  input wire bli_ramp_t ramp,
  output bli_upd_t upd
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [31:0] hold_ff;
  logic [31:0] active_ff;
  logic [31:0] ctrl_ff;
  logic [BLI_ADDR_W-1:0] awaddr_ff;
  logic aw_got_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_got_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  bli_upd_t upd_ff;

  // ****************************************
  // Bus handshakes
  // ****************************************
  // One write at a time: each channel stalls once captured until the answer drains
  assign s_axi_awready = ce && !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = ce && !w_got_ff && !bvalid_ff;
  assign s_axi_arready = ce && !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [BLI_ADDR_W-1:0] wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  wire wr_fire = ce && (aw_got_ff || aw_take) && (w_got_ff || w_take);

  wire wr_interval = wr_fire && (wr_addr == BLI_OFF_INTERVAL);
  wire wr_ctrl = wr_fire && (wr_addr == BLI_OFF_CTRL);
  wire wr_known = (wr_addr == BLI_OFF_INTERVAL) || (wr_addr == BLI_OFF_CTRL)
    || (wr_addr == BLI_OFF_STATUS);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // Segment index and field selection
  // ****************************************
  wire ramp_shape_select = ctrl_ff[BLI_CTRL_SHAPE_BIT];
  wire update_apply = ctrl_ff[BLI_CTRL_APPLY_BIT];

  wire [BLI_IDX_W-1:0] idx_sym = ramp.duty_cycle[BLI_DUTY_SYM_LSB +: BLI_IDX_W];
  wire [BLI_IDX_W-1:0] idx_asym = {ramp.falling_phase_flag,
    ramp.duty_cycle[BLI_DUTY_ASYM_LSB +: BLI_IDX_W-1]};
  wire [BLI_IDX_W-1:0] segment_index = ramp_shape_select ? idx_asym : idx_sym;

  wire [BLI_FIELD_W-1:0] segment_zero_wait = active_ff[0 +: BLI_FIELD_W];
  wire [BLI_FIELD_W-1:0] segment_seven_wait = active_ff[(BLI_NUM_SEG-1)*BLI_FIELD_W +: BLI_FIELD_W];
  wire [BLI_FIELD_W-1:0] sel_wait = active_ff[segment_index*BLI_FIELD_W +: BLI_FIELD_W];

  // ****************************************
  // Interval counter
  // ****************************************
  logic cnt_done;
  logic [BLI_FIELD_W-1:0] cnt_value;

  bli_period_cnt #(
    .WIDTH(BLI_FIELD_W)
  ) u_cnt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tick(ramp.period_end),
    .limit(sel_wait),
    .done(cnt_done),
    .count(cnt_value)
  );

  bli_upd_t nxt_upd;
  assign nxt_upd = '{segment_index: segment_index, wait_periods: sel_wait,
    duty_update: cnt_done};
  assign upd = upd_ff;

  // ****************************************
  // Read decode
  // ****************************************
  wire [31:0] status_word = (32'(segment_index) << BLI_STS_IDX_LSB)
    | (32'(sel_wait) << BLI_STS_SEL_LSB) | (32'(cnt_value) << BLI_STS_CNT_LSB);
  wire [31:0] rd_word = (s_axi_araddr == BLI_OFF_INTERVAL) ? active_ff
    : (s_axi_araddr == BLI_OFF_CTRL) ? ctrl_ff
    : (s_axi_araddr == BLI_OFF_STATUS) ? status_word : 32'h0000_0000;
  wire rd_known = (s_axi_araddr == BLI_OFF_INTERVAL) || (s_axi_araddr == BLI_OFF_CTRL)
    || (s_axi_araddr == BLI_OFF_STATUS);

  // ****************************************
  // Registers
  // ****************************************
  // holding copy takes writes
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_ff <= BLI_INTERVAL_RST;
    end else if (ce && wr_interval) begin
      hold_ff <= merge(hold_ff, wr_data, wr_strb);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_ff <= BLI_INTERVAL_RST;
    end else if (ce && ramp.period_end && update_apply) begin
      active_ff <= hold_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= BLI_CTRL_RST;
    end else if (ce && wr_ctrl) begin
      ctrl_ff <= merge(ctrl_ff, wr_data, wr_strb) & 32'h0000_0003;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      upd_ff <= '0;
    end else if (ce) begin
      upd_ff <= nxt_upd;
    end
  end

  // Write channel capture
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (ce) begin
      aw_got_ff <= wr_fire ? 1'b0 : (aw_got_ff || aw_take);
      w_got_ff <= wr_fire ? 1'b0 : (w_got_ff || w_take);
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= BLI_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? BLI_RESP_OKAY : BLI_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= BLI_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= rd_known ? BLI_RESP_OKAY : BLI_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_commit;
    @(posedge clk) disable iff (rst)
    (ce && ramp.period_end && update_apply) |=> (active_ff == $past(hold_ff));
  endproperty
  a_commit: assert property (p_commit) else $error("holding copy not committed");

  property p_no_commit;
    @(posedge clk) disable iff (rst)
    (!(ramp.period_end && update_apply && ce)) |=> $stable(active_ff);
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("active changed outside commit");

  property p_idx_sym;
    @(posedge clk) disable iff (rst)
    (ce && !ramp_shape_select) |=> (upd.segment_index == $past(ramp.duty_cycle[7:5]));
  endproperty
  a_idx_sym: assert property (p_idx_sym) else $error("symmetric index wrong");

  property p_idx_asym;
    @(posedge clk) disable iff (rst)
    (ce && ramp_shape_select) |=> (upd.segment_index
      == {$past(ramp.falling_phase_flag), $past(ramp.duty_cycle[7:6])});
  endproperty
  a_idx_asym: assert property (p_idx_asym) else $error("asymmetric index wrong");

  property p_field_pick;
    @(posedge clk) disable iff (rst)
    ce |=> (upd.wait_periods
      == BLI_FIELD_W'($past(active_ff) >> (32'(upd.segment_index) * BLI_FIELD_W)));
  endproperty
  a_field_pick: assert property (p_field_pick) else $error("wrong nibble selected");

  property p_seg_zero;
    @(posedge clk) disable iff (rst)
    (segment_index == 3'h0) |-> (sel_wait == segment_zero_wait);
  endproperty
  a_seg_zero: assert property (p_seg_zero) else $error("segment zero field wrong");

  property p_seg_seven;
    @(posedge clk) disable iff (rst)
    (segment_index == 3'h7) |-> (sel_wait == segment_seven_wait);
  endproperty
  a_seg_seven: assert property (p_seg_seven) else $error("segment seven field wrong");

  property p_wait_len;
    @(posedge clk) disable iff (rst)
    (ce && ramp.period_end && cnt_value == sel_wait) |=> upd.duty_update;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("update missed at interval");

  property p_update_cause;
    @(posedge clk) disable iff (rst)
    $rose(upd.duty_update) |-> $past(ramp.period_end && ce) && cnt_value == 4'h0;
  endproperty
  a_update_cause: assert property (p_update_cause) else $error("update without period end");

  property p_read_active;
    @(posedge clk) disable iff (rst)
    (ar_take && s_axi_araddr == BLI_OFF_INTERVAL) |=> (s_axi_rdata == $past(active_ff));
  endproperty
  a_read_active: assert property (p_read_active) else $error("read not active copy");

  c_commit: cover property (@(posedge clk) disable iff (rst)
    ce && ramp.period_end && update_apply && hold_ff != active_ff);
  c_long_wait: cover property (@(posedge clk) disable iff (rst)
    upd.duty_update && upd.wait_periods == 4'hF);
  c_asym: cover property (@(posedge clk) disable iff (rst)
    upd.duty_update && ramp_shape_select && ramp.falling_phase_flag);
  c_slverr: cover property (@(posedge clk) disable iff (rst)
    s_axi_rvalid && s_axi_rresp == BLI_RESP_SLVERR);

endmodule

// *** src/bli_period_cnt.sv ***
// Counter of PWM period ends that fires once every limit plus one ends
module bli_period_cnt #(
  parameter int unsigned WIDTH = 4
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Counting
  input wire logic tick,
  input wire logic [WIDTH-1:0] limit,
  output logic done,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  wire reached = (cnt_ff >= limit);

  // Limit may shrink under a running count, so >= avoids a wrap to a long wait
  assign done = tick && reached;
  assign count = cnt_ff;
  assign nxt_cnt = done ? '0 : (tick ? WIDTH'(cnt_ff + 1'b1) : cnt_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// *** src/bli_pkg.sv ***
// Shared constants and carrier types for the segment update-interval stage
package bli_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned BLI_ADDR_W = 8;
  localparam logic [BLI_ADDR_W-1:0] BLI_OFF_INTERVAL = 8'h10;
  localparam logic [BLI_ADDR_W-1:0] BLI_OFF_CTRL = 8'h14;
  localparam logic [BLI_ADDR_W-1:0] BLI_OFF_STATUS = 8'h18;

  localparam logic [31:0] BLI_INTERVAL_RST = 32'h0000_0000;
  localparam logic [31:0] BLI_CTRL_RST = 32'h0000_0000;

  // Control register bit positions
  localparam int unsigned BLI_CTRL_SHAPE_BIT = 0;
  localparam int unsigned BLI_CTRL_APPLY_BIT = 1;

  // Status register field positions
  localparam int unsigned BLI_STS_IDX_LSB = 0;
  localparam int unsigned BLI_STS_SEL_LSB = 4;
  localparam int unsigned BLI_STS_CNT_LSB = 8;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int unsigned BLI_FIELD_W = 4;
  localparam int unsigned BLI_NUM_SEG = 8;
  localparam int unsigned BLI_IDX_W = 3;
  localparam int unsigned BLI_DUTY_W = 8;
  localparam int unsigned BLI_DUTY_SYM_LSB = 5;
  localparam int unsigned BLI_DUTY_ASYM_LSB = 6;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] BLI_RESP_OKAY = 2'h0;
  localparam logic [1:0] BLI_RESP_SLVERR = 2'h2;

  // Link from the duty-cycle side of the unit
  typedef struct packed {
    logic [BLI_DUTY_W-1:0] duty_cycle;
    logic falling_phase_flag;
    logic period_end;
  } bli_ramp_t;

  // What this stage hands back to the duty-cycle stepper
  typedef struct packed {
    logic [BLI_IDX_W-1:0] segment_index;
    logic [BLI_FIELD_W-1:0] wait_periods;
    logic duty_update;
  } bli_upd_t;

endpackage
